// *** rtl/pfs_pkg.sv ***
// Shared constants, types and state layout for the power fault supervisor.
//
// Contract
// - Over-power timer starts when peak exceeds threshold
// - Timer of 160 ms expires: stop, recovery delay
// - Output sense hysteresis picks high or low threshold set
// - Maximum peak level is four thirds of threshold
// - Peak command clamped to the maximum level
// - At supply off, short check starts recovery
// - No short at supply off: plain undervoltage restart
// - Three consecutive over-current cycles trigger fault
// - No low-side pulses while any fault pends
// - Restart only after recovery then supply off
// - Reference not good ends switching, full restart
// - Die over-temperature starts undervoltage restart cycle
// - Still hot after cycle: repeat protection cycle
package pfs_pkg;

  // ----------------------------------------------------------------
  // Timing and widths
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 125000;                 // System clock rate in kHz
  localparam int OPP_TIME_MS = 160;                // Over-power persistence time
  localparam int FDR_TIME_MS = 1500;               // Fault recovery delay
  localparam int OPP_CYC = OPP_TIME_MS * CLK_KHZ;  // Longest time: exact here, no rounding needed
  localparam int FDR_CYC = FDR_TIME_MS * CLK_KHZ;  // Least time: exact here
  localparam int CNT_W = 28;                       // Holds both interval counts
  localparam int CODE_W = 10;                      // Current-sense threshold code width
  localparam int OCP_LIMIT = 3;                    // Consecutive over-current cycles to trip
  localparam int FLAG_W = 9;                       // Number of analog comparator flags

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Supervisor sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,      // Supply below start level or waiting to start
    ST_RUN,       // Switching allowed
    ST_UVLO,      // Switching stopped, waiting for supply off
    ST_FDR,       // Recovery delay counting
    ST_FDR_DONE,  // Delay done, waiting for supply off
    ST_LATCH      // Latched fault, only reset clears it
  } sup_state_t;

  // Comparator flags from the analog front end
  typedef struct packed {
    logic cs_opp;      // Peak sense above over-power threshold
    logic cs_ocp;      // Current sense above over-current level
    logic vs_hi;       // Output sense above upper set level
    logic vs_lo;       // Output sense below lower set level
    logic vs_short;    // Output sense below short level
    logic ref_good;    // Reference above power-good level
    logic die_hot;     // Die temperature trip
    logic supply_off;  // Supply at its turn-off level
    logic supply_on;   // Supply at its turn-on level
  } flags_t;

  // Threshold code pair for the two threshold sets
  typedef struct packed {
    logic [CODE_W-1:0] high_set;  // Two-segment set
    logic [CODE_W-1:0] low_set;   // One-segment set
  } thr_pair_t;

  // Whole register state of the supervisor
  typedef struct packed {
    sup_state_t st;             // Sequencing state
    logic [CNT_W-1:0] opp_cnt;  // Over-power timer
    logic [CNT_W-1:0] fdr_cnt;  // Recovery timer
    logic [1:0] ocp_cnt;        // Consecutive over-current cycles
    logic ocp_seen;             // Exceedance seen in current cycle
    logic set_hi;               // High threshold set selected
    logic [CODE_W-1:0] thr;     // Active over-power threshold
    logic [CODE_W:0] max_lvl;   // Maximum controllable peak level
    logic [CODE_W:0] cmd;       // Clamped peak command
  } sup_regs_t;

  localparam sup_regs_t REGS_RST = '0;  // Idle, counters clear, low set
endpackage

// *** rtl/flag_sync.sv ***
// Two-flop synchroniser bank for asynchronous comparator flags.
module flag_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second

  // Refused at elaboration: an empty bank has nothing to carry
  if (WIDTH < 1) begin
    $error("flag_sync WIDTH must be at least 1");
  end

  // Both stages clear on reset; flags read as inactive until settled
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** rtl/power_fault_supervisor.sv ***
// Fault supervision: over-power timer, peak limit, over-current, short and shutdown sequencing.
module power_fault_supervisor
  import pfs_pkg::*;
#(
  parameter int OPP_CYCLES = pfs_pkg::OPP_CYC,  // Over-power persistence in clocks
  parameter int FDR_CYCLES = pfs_pkg::FDR_CYC   // Recovery delay in clocks
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,                              // Supply undervoltage reset
  input wire pfs_pkg::flags_t flags_in,                   // Asynchronous comparator flags
  input wire pfs_pkg::thr_pair_t thr_codes_in,            // Threshold codes per set
  input wire logic [pfs_pkg::CODE_W:0] peak_cmd_in,       // Requested peak command
  input wire logic ocp_window_in,                         // After blanking, before demag end
  input wire logic cycle_end_in,                          // Low-side cycle completed pulse
  input wire logic auto_recovery_in,                      // High: auto-recovery, low: latch
  output logic low_side_gate_enable_out,                  // Low-side switching allowed
  output logic run_out,                                   // Run pin level
  output logic fault_pending_out,                         // Protection fault pending
  output logic opp_set_hi_out,                            // High threshold set active
  output logic [pfs_pkg::CODE_W-1:0] over_power_threshold_out,
  output logic [pfs_pkg::CODE_W:0] max_peak_current_level_out,
  output logic [pfs_pkg::CODE_W:0] peak_cmd_out           // Clamped peak command
);
  import pfs_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // Refused at elaboration: the timers must fit their counters
  if (OPP_CYCLES < 2 || OPP_CYCLES >= (1 << CNT_W)) begin
    $error("OPP_CYCLES out of range");
  end
  if (FDR_CYCLES < 2 || FDR_CYCLES >= (1 << CNT_W)) begin
    $error("FDR_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] OPP_LAST = CNT_W'(OPP_CYCLES - 1);  // Final timer count
  localparam logic [CNT_W-1:0] FDR_LAST = CNT_W'(FDR_CYCLES - 1);
  localparam logic [1:0] OCP_LAST = 2'(OCP_LIMIT - 1);             // Count before trip

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  flags_t f;             // Synchronised flags
  sup_regs_t s_r;        // Registered state
  sup_regs_t s_nxt;      // Next state
  logic opp_expire;      // Over-power persisted full time
  logic ocp_trip;        // Third consecutive over-current cycle
  logic short_seen;      // Output short or peak above over-power threshold
  logic protect_fault;   // Any fault asking for the recovery delay

  // Comparator flags cross into the clock domain here
  flag_sync #(
    .WIDTH(FLAG_W)
  ) u_flag_sync (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .async_in(flags_in),
    .sync_out(f)
  );

  // ----------------------------------------------------------------
  // Fault detection terms
  // ----------------------------------------------------------------
  // Decodes shared by the next-state logic and the checks
  always_comb begin
    opp_expire = (s_r.st == ST_RUN) && f.cs_opp && (s_r.opp_cnt == OPP_LAST);
    ocp_trip = (s_r.st == ST_RUN) && cycle_end_in && (s_r.ocp_seen || (f.cs_ocp && ocp_window_in))
               && (s_r.ocp_cnt == OCP_LAST);
    short_seen = f.cs_opp || f.vs_short;
    protect_fault = opp_expire || ocp_trip || ((s_r.st == ST_RUN) && f.supply_off && short_seen);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Threshold set hysteresis: between the levels the set holds
    if (f.vs_hi) begin
      s_nxt.set_hi = 1'b1;
    end else if (f.vs_lo) begin
      s_nxt.set_hi = 1'b0;
    end
    s_nxt.thr = s_r.set_hi ? thr_codes_in.high_set : thr_codes_in.low_set;
    // Fixed ratio of four thirds, whichever set is active
    s_nxt.max_lvl = {1'b0, s_r.thr} + (CODE_W + 1)'({1'b0, s_r.thr} / (CODE_W + 1)'(3));
    // Command may reach but never pass the registered limit
    s_nxt.cmd = (peak_cmd_in > s_r.max_lvl) ? s_r.max_lvl : peak_cmd_in;

    // Over-power timer only runs while switching and above threshold
    if ((s_r.st == ST_RUN) && f.cs_opp) begin
      if (s_r.opp_cnt != OPP_LAST) begin
        s_nxt.opp_cnt = s_r.opp_cnt + CNT_W'(1);
      end
    end else begin
      s_nxt.opp_cnt = '0;
    end

    // Over-current tracking per low-side cycle
    if (s_r.st != ST_RUN) begin
      s_nxt.ocp_cnt = '0;
      s_nxt.ocp_seen = 1'b0;
    end else if (cycle_end_in) begin
      if (s_r.ocp_seen || (f.cs_ocp && ocp_window_in)) begin
        s_nxt.ocp_cnt = (s_r.ocp_cnt == OCP_LAST) ? s_r.ocp_cnt : s_r.ocp_cnt + 2'd1;
      end else begin
        s_nxt.ocp_cnt = '0;
      end
      s_nxt.ocp_seen = 1'b0;
    end else if (f.cs_ocp && ocp_window_in) begin
      s_nxt.ocp_seen = 1'b1;
    end

    // Recovery timer is only cleared when a protection fault leaves the run state
    if (s_r.st == ST_FDR && s_r.fdr_cnt != FDR_LAST) begin
      s_nxt.fdr_cnt = s_r.fdr_cnt + CNT_W'(1);
    end

    // Sequencing
    case (s_r.st)
      ST_IDLE: begin
        // Start needs supply up, reference released and die cool
        if (f.supply_on) begin
          if (!f.ref_good || f.die_hot) begin
            s_nxt.st = ST_UVLO;
          end else begin
            s_nxt.st = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        if (!f.ref_good || f.die_hot) begin
          s_nxt.st = ST_UVLO;
        end else if (protect_fault) begin
          s_nxt.fdr_cnt = '0;
          s_nxt.st = auto_recovery_in ? ST_FDR : ST_LATCH;
        end else if (f.supply_off) begin
          s_nxt.st = ST_IDLE;
        end
      end
      ST_UVLO: begin
        // Wait for the supply to collapse; restart is a fresh cycle
        if (f.supply_off) begin
          s_nxt.st = ST_IDLE;
        end
      end
      ST_FDR: begin
        if (s_r.fdr_cnt == FDR_LAST) begin
          s_nxt.st = ST_FDR_DONE;
        end
      end
      ST_FDR_DONE: begin
        if (f.supply_off) begin
          s_nxt.st = ST_IDLE;
        end
      end
      ST_LATCH: begin
        s_nxt.st = ST_LATCH;  // Held until undervoltage reset
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all decoded from registered state
  // ----------------------------------------------------------------
  // Only the run state may pulse; faults get no trial pulses
  assign low_side_gate_enable_out = (s_r.st == ST_RUN);
  assign run_out = (s_r.st == ST_RUN);
  assign fault_pending_out = (s_r.st == ST_FDR) || (s_r.st == ST_FDR_DONE) || (s_r.st == ST_LATCH);
  assign opp_set_hi_out = s_r.set_hi;
  assign over_power_threshold_out = s_r.thr;
  assign max_peak_current_level_out = s_r.max_lvl;
  assign peak_cmd_out = s_r.cmd;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  opp_count_a: assert property (s_r.opp_cnt != '0 |-> $past(f.cs_opp))
    else $error("Over-power timer ran without exceedance");
  opp_expire_a: assert property (opp_expire && f.ref_good && !f.die_hot |=> fault_pending_out)
    else $error("Over-power expiry did not raise fault");
  set_select_a: assert property (f.vs_hi |=> opp_set_hi_out ##1 (f.vs_lo || over_power_threshold_out == $past(thr_codes_in.high_set)))
    else $error("Threshold set not selected");
  ppl_ratio_a: assert property (##1 max_peak_current_level_out == $past({1'b0, s_r.thr}) + $past({1'b0, s_r.thr}) / 3)
    else $error("Peak limit ratio wrong");
  cmd_cap_a: assert property (peak_cmd_out <= $past(max_peak_current_level_out))
    else $error("Peak command exceeds limit");
  short_a: assert property (run_out && f.supply_off && f.vs_short && f.ref_good && !f.die_hot && auto_recovery_in
    |=> s_r.st == ST_FDR && s_r.fdr_cnt == '0)
    else $error("Short at supply off missed");
  uv_only_a: assert property (run_out && f.supply_off && !short_seen && !opp_expire && !ocp_trip && f.ref_good
    && !f.die_hot |=> s_r.st == ST_IDLE)
    else $error("Plain undervoltage restart not taken");
  ocp_trip_a: assert property (ocp_trip && f.ref_good && !f.die_hot |=> !run_out ##0 fault_pending_out)
    else $error("Over-current trip missed");
  no_pulse_a: assert property (fault_pending_out |-> !low_side_gate_enable_out)
    else $error("Pulse during fault");
  fdr_order_a: assert property (s_r.st == ST_FDR |=> s_r.st inside {ST_FDR, ST_FDR_DONE} ##0 !run_out)
    else $error("Left recovery early");
  ref_drop_a: assert property (run_out && !f.ref_good |=> !low_side_gate_enable_out [*2])
    else $error("Switching not ended on reference loss");
  hot_start_a: assert property (s_r.st == ST_IDLE && f.die_hot |=> !run_out)
    else $error("Started while hot");
  ocp_clear_a: assert property (run_out && cycle_end_in && !s_r.ocp_seen && !(f.cs_ocp && ocp_window_in)
    |=> s_r.ocp_cnt == '0)
    else $error("Over-current count not cleared");

  opp_fault_c: cover property (opp_expire ##1 s_r.st == ST_FDR);
  fdr_restart_c: cover property (s_r.st == ST_FDR_DONE ##1 s_r.st == ST_IDLE);
  ocp_fault_c: cover property (ocp_trip);
  short_c: cover property (run_out && f.supply_off && short_seen);
  latch_c: cover property (s_r.st == ST_LATCH);
endmodule

// *** test/pfs_front_end_model.sv ***
// Behavioural model of the analog comparators and power stage facing the supervisor.
module pfs_front_end_model
  import pfs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire pfs_pkg::flags_t want_in,  // Conditions requested by the bench
  input wire logic gate_en_in,          // Low-side switching allowed
  output pfs_pkg::flags_t flags_out     // Comparator levels toward the supervisor
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Comparator outputs
  // ----------------------------------------
  initial flags_out = '0;
  // Comparators settle one clock after the analog condition changes
  always @(posedge clk_sys_in) begin
    flags_out <= want_in;
    // With switching stopped no primary current flows, so neither current-sense level can exceed
    if (!gate_en_in) begin
      flags_out.cs_ocp <= 1'b0;
      flags_out.cs_opp <= 1'b0;
    end
    // Reference stays below good for as long as the external pull-down is held
    flags_out.ref_good <= want_in.ref_good;
  end
endmodule

// *** test/test_power_fault_supervisor.sv ***
// Self-checking bench for the power fault supervisor.
module test_power_fault_supervisor
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  `define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
  localparam int OPP_N = 40;  // Shortened over-power time
  localparam int FDR_N = 60;  // Shortened recovery delay
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  flags_t want = '0;  // Requested analog conditions
  flags_t flags;
  thr_pair_t thr_codes = {10'h012C, 10'h00C0};
  logic [CODE_W:0] peak_cmd = 11'h01FF;
  logic ocp_window = 1'b0;
  logic cycle_end = 1'b0;
  logic auto_rec = 1'b1;  // Auto-recovery mode select
  logic gate_en, run, fault, set_hi;
  logic [CODE_W-1:0] thr;
  logic [CODE_W:0] max_lvl, cmd;
  int errors = 0;
  int comparisons = 0;
  // Clock of 8 ns
  always #4 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  power_fault_supervisor #(.OPP_CYCLES(OPP_N), .FDR_CYCLES(FDR_N)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .flags_in(flags), .thr_codes_in(thr_codes),
    .peak_cmd_in(peak_cmd), .ocp_window_in(ocp_window), .cycle_end_in(cycle_end),
    .auto_recovery_in(auto_rec), .low_side_gate_enable_out(gate_en), .run_out(run),
    .fault_pending_out(fault), .opp_set_hi_out(set_hi), .over_power_threshold_out(thr),
    .max_peak_current_level_out(max_lvl), .peak_cmd_out(cmd));
  pfs_front_end_model u_front (.clk_sys_in(clk_sys_in), .want_in(want), .gate_en_in(gate_en),
    .flags_out(flags));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Supply falls to off, then rises to on; flags need four edges to act
  task automatic supply_cycle();
    want.supply_off = 1'b1;
    tick(4);
    want.supply_off = 1'b0;
    want.supply_on = 1'b1;
    tick(5);
    want.supply_on = 1'b0;
  endtask
  // Bench's own figure for the peak limit, four thirds truncated
  function automatic logic [CODE_W:0] limit_of(input logic [CODE_W-1:0] t);
    return (CODE_W + 1)'({1'b0, t} + {1'b0, t} / 3);
  endfunction
  task automatic complete_run();
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Over-power persistence, interruption and recovery ordering
  task automatic opp_case();
    want.cs_opp = 1'b1;
    tick(30);
    want.cs_opp = 1'b0;
    tick(2);
    want.cs_opp = 1'b1;
    tick(30);
    `CHECK(run, 1'b1)
    tick(15);
    `CHECK(run, 1'b0)
    `CHECK(fault, 1'b1)
    want.cs_opp = 1'b0;
    supply_cycle();
    `CHECK(gate_en, 1'b0)
    `CHECK(fault, 1'b1)
    tick(FDR_N);
    supply_cycle();
    `CHECK(run, 1'b1)
  endtask
  // Threshold set choice, peak limit and command clamp
  task automatic limit_case();
    want.vs_hi = 1'b1;
    tick(8);
    `CHECK(set_hi, 1'b1)
    `CHECK(thr, thr_codes.high_set)
    `CHECK(max_lvl, limit_of(thr_codes.high_set))
    `CHECK(cmd, limit_of(thr_codes.high_set))
    want.vs_hi = 1'b0;
    want.vs_lo = 1'b1;
    peak_cmd = limit_of(thr_codes.low_set);
    tick(8);
    `CHECK(set_hi, 1'b0)
    `CHECK(max_lvl, limit_of(thr_codes.low_set))
    `CHECK(cmd, peak_cmd)
  endtask
  // One low-side cycle, with or without an over-current exceedance
  task automatic ocp_cycle(input logic hit);
    ocp_window = 1'b1;
    want.cs_ocp = hit;
    tick(4);
    cycle_end = 1'b1;
    tick(1);
    cycle_end = 1'b0;
    ocp_window = 1'b0;
    want.cs_ocp = 1'b0;
    tick(3);
  endtask
  task automatic ocp_case();
    ocp_cycle(1'b1);
    ocp_cycle(1'b1);
    ocp_cycle(1'b0);
    ocp_cycle(1'b1);
    ocp_cycle(1'b1);
    `CHECK(run, 1'b1)
    ocp_cycle(1'b1);
    `CHECK(run, 1'b0)
    `CHECK(fault, 1'b1)
    tick(FDR_N);
    supply_cycle();
  endtask
  // Supply-off short check against a plain undervoltage restart
  task automatic short_case();
    want.vs_short = 1'b1;
    want.supply_off = 1'b1;
    tick(5);
    `CHECK(fault, 1'b1)
    want = '{ref_good: 1'b1, vs_lo: 1'b1, default: 1'b0};
    tick(FDR_N);
    supply_cycle();
    supply_cycle();
    `CHECK(fault, 1'b0)
    `CHECK(run, 1'b1)
  endtask
  // Reference loss and die temperature cycles
  task automatic shutdown_case();
    want.ref_good = 1'b0;
    tick(5);
    `CHECK(run, 1'b0)
    `CHECK(fault, 1'b0)
    supply_cycle();
    `CHECK(run, 1'b0)
    want.ref_good = 1'b1;
    supply_cycle();
    want.die_hot = 1'b1;
    tick(5);
    `CHECK(run, 1'b0)
    supply_cycle();
    `CHECK(run, 1'b0)
    want.die_hot = 1'b0;
    supply_cycle();
    `CHECK(run, 1'b1)
  endtask
  // Latch mode keeps a fault through a supply cycle until a mid-run reset
  task automatic latch_case();
    auto_rec = 1'b0;
    want.vs_short = 1'b1;
    want.supply_off = 1'b1;
    tick(5);
    `CHECK(gate_en, 1'b0)
    want.vs_short = 1'b0;
    tick(FDR_N);
    supply_cycle();
    `CHECK(fault, 1'b1)
    rst_b_in = 1'b0;
    tick(1);
    `CHECK(fault, 1'b0)
    tick(1);
    rst_b_in = 1'b1;
    auto_rec = 1'b1;
    supply_cycle();
    `CHECK(run, 1'b1)
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    tick(2);
    rst_b_in = 1'b1;
    want.ref_good = 1'b1;
    want.vs_lo = 1'b1;
    tick(1);
    want.supply_on = 1'b1;
    tick(5);
    want.supply_on = 1'b0;
    `CHECK(run, 1'b1)
    limit_case();
    opp_case();
    ocp_case();
    short_case();
    shutdown_case();
    latch_case();
    complete_run();
  end
  // The whole run needs about 510 clocks; allow several times that
  initial begin
    #40000;
    errors++;
    complete_run();
  end
endmodule
